// *** include/thcp_regs.vh ***
// register map, field positions and delay counts of the tuner host port
`ifndef THCP_REGS_VH
`define THCP_REGS_VH

// host select line codes
`define THCP_SEL_STAGE0     3'h0
`define THCP_SEL_STAGE1     3'h1
`define THCP_SEL_STAGE2     3'h2
`define THCP_SEL_STAGE3     3'h3
`define THCP_SEL_DEST       3'h4

// destination codes, low nibble of the selector byte
`define THCP_DEST_W         4
`define THCP_DEST_CARRIER   4'h0
`define THCP_DEST_RESAMPLER 4'h1
`define THCP_DEST_TEST      4'h8
`define THCP_DEST_SNAPSHOT  4'h9
`define THCP_NUM_CTRL       9

// word layout
`define THCP_WORD_W         32
`define THCP_BYTE_W         8
`define THCP_WORD_RESET     32'h0000_0000
`define THCP_BYTE_RESET     8'h00

// test register fields
`define THCP_TEST_EN_BIT     31
`define THCP_TEST_SERIAL_BIT 30

// delays in device clocks
`define THCP_CNT_W          3
`define THCP_COMMIT_CLKS    3'h4
`define THCP_CNT_START      3'h1
`define THCP_CNT_ONE        3'h1
`define THCP_CNT_ZERO       3'h0

`endif

// *** testbench/tb_top.sv ***
// self-checking bench for the tuner host control port
`timescale 1ns/1ps
module tb_top;
   logic         clock_i;
   logic         rst_i;
   logic [31:0]  offset;
   logic [7:0]   gain;
   logic [15:0]  func;
   logic [287:0] prev;
   logic         oe_prev;
   logic [7:0]   stg [4];
   logic [35:0]  expq [$];
   logic [31:0]  v;
   integer       seed;
   integer       n_mismatch;
   integer       n_tests;
   wire  [2:0]   sel;
   wire  [7:0]   hdata;
   wire          wr_n;
   wire          rd_n;
   wire          load;
   wire  [7:0]   bus_o;
   wire          oe_n;
   wire  [287:0] words;
   wire  [7:0]   bus_i = oe_n ? hdata : bus_o;

   thcp_host_model host (.clock_i(clock_i), .sel_o(sel), .data_o(hdata),
      .wr_n_o(wr_n), .rd_n_o(rd_n), .load_o(load));
   thcp_top DUT (.clock_i(clock_i), .rst_i(rst_i),
      .host_select_lines_i(sel), .host_byte_lines_i(bus_i),
      .host_byte_lines_o(bus_o), .host_byte_lines_oe_n_o(oe_n),
      .wr_n_i(wr_n), .rd_n_i(rd_n), .direct_freq_commit_i(load),
      .carrier_offset_serial_i(offset), .gain_control_loop_exp_i(gain[7:5]),
      .gain_control_loop_frac_i(gain[4:0]), .func_pins_i(func),
      .out_pins_o(), .carrier_center_frequency_o(),
      .resampler_center_frequency_o(), .phase_oscillator_freq_o(),
      .control_words_o(words));

   initial
   begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   task automatic chk(input string nm, input logic [35:0] e,
                      input logic [35:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic take(input logic [3:0] i, input logic [31:0] g);
      logic [35:0] e;
      e = expq.size() ? expq.pop_front() : 36'hx;
      chk("result", e, {i, g});
   endtask
   task automatic stage(input int k, input logic [7:0] d);
      stg[k] = d;
      host.write(k[2:0], d);
   endtask
   task automatic commit(input logic [3:0] d);
      if (d < 4'h9)
         expq.push_back({d, stg[3], stg[2], stg[1], stg[0]});
      host.write(3'h4, {v[7:4], d});
      repeat (8) @(negedge clock_i);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // watcher: every result takes the oldest note
   always @(negedge clock_i)
   begin
      if (!rst_i)
      begin
         for (int k = 0; k < 9; k++)
            if (words[k*32 +: 32] !== prev[k*32 +: 32])
               take(k[3:0], words[k*32 +: 32]);
         if (!oe_n && oe_prev)
            take(4'hf, {24'h0, bus_o});
      end
      prev = words;
      oe_prev = oe_n;
   end
   always @(negedge clock_i)
      func <= $random(seed);
   initial
   begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      $display("BAD timeout expected 0 seen 1");
      conclude();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      seed = 32'h92e7;
      n_mismatch = 0;
      n_tests = 0;
      rst_i = 1'b1;
      func = 16'h0000;
      gain = 8'h00;
      offset = $random(seed);
      oe_prev = 1'b1;
      stg = '{default: 8'h00};
      repeat (16) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      chk("reset_words", 36'h0, {35'h0, |words});
      chk("reset_oe_n", 36'h1, {35'h0, oe_n});
      $display("test reset done");
      for (int d = 0; d < 9; d++)
      begin
         v = $random(seed);
         for (int k = 0; k < 4; k++)
            stage(k, v[k*8 +: 8]);
         commit(d[3:0]);
      end
      $display("test destinations done");
      v = $random(seed);
      stage(1, v[7:0]);
      for (int k = 5; k < 8; k++)
         host.write(k[2:0], v[15:8]);
      for (int d = 10; d < 16; d++)
         commit(d[3:0]);
      commit(4'h2);
      $display("test partial and refused done");
      stage(2, v[23:16]);
      repeat (3) @(negedge clock_i);
      expq.push_back({4'h0, stg[3], stg[2], stg[1], stg[0]});
      host.load();
      stage(0, v[31:24]);
      commit(4'h0);
      $display("test direct load done");
      gain = v[15:8];
      commit(4'h9);
      expq.push_back({4'hf, 24'h0, v[15:8]});
      host.read();
      $display("test snapshot done");
      for (int m = 3; m >= 0; m--)
      begin
         stage(3, {m[1:0], v[5:0]});
         commit(4'h8);
      end
      $display("test pin forcing done");
      chk("queue_left", 36'h0, 36'(expq.size()));
      conclude();
   end
endmodule // tb_top

// *** testbench/thcp_chk_sva.sv ***
// assertions on the tuner host control port pins
`timescale 1ns/1ps
module thcp_chk
#(
   parameter             OUT_W       = 16,
   parameter [OUT_W-1:0] SERIAL_MASK = 16'h00FF
)
(
   input wire             clock_i,
   input wire             rst_i,
   input wire             wr_n_i,
   input wire             rd_n_i,
   input wire             direct_freq_commit_i,
   input wire [31:0]      carrier_offset_serial_i,
   input wire [OUT_W-1:0] func_pins_i,
   input wire [7:0]       host_byte_lines_o,
   input wire             host_byte_lines_oe_n_o,
   input wire [OUT_W-1:0] out_pins_o,
   input wire [31:0]      carrier_center_frequency_o,
   input wire [31:0]      resampler_center_frequency_o,
   input wire [31:0]      phase_oscillator_freq_o,
   input wire [287:0]     control_words_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic [3:0]       since_wr_reg;
   logic             wr_q_reg;
   wire  [OUT_W-1:0] lvl = control_words_o[256 +: OUT_W];
   wire              t_en = control_words_o[287];
   wire              s_en = control_words_o[286];
   // ==========================================================
   // cycles since the write strobe pin rose
   always @(posedge clock_i)
   begin
      wr_q_reg <= rst_i | wr_n_i;
      if (rst_i)
         since_wr_reg <= 4'hf;
      else if (wr_n_i && !wr_q_reg)
         since_wr_reg <= 4'h0;
      else if (since_wr_reg != 4'hf)
         since_wr_reg <= since_wr_reg + 4'h1;
   end
   sequence s_rd_low;
      !rd_n_i [*4];
   endsequence
   sequence s_rd_high;
      rd_n_i [*4];
   endsequence
   // ==========================================================
   // properties
   a_word_mirror: assert property (
      carrier_center_frequency_o == control_words_o[31:0] &&
      resampler_center_frequency_o == control_words_o[63:32])
      else $error("frequency port differs from control word");
   // sync skew lets the commit land a few cycles either way
   a_commit_slot: assert property (
      !$past(rst_i) && $changed(control_words_o) |->
      $past(direct_freq_commit_i) ||
      (since_wr_reg > 4'h2 && since_wr_reg < 4'ha))
      else $error("control word changed without a load cause");
   a_phase_sum: assert property (
      !$past(rst_i) |-> phase_oscillator_freq_o ==
      $past(control_words_o[31:0]) + $past(carrier_offset_serial_i))
      else $error("mixer word is not centre plus offset");
   a_bus_release: assert property (
      s_rd_high |=> host_byte_lines_oe_n_o)
      else $error("bus still driven after read strobe rose");
   a_read_drive: assert property (
      s_rd_low |=> !host_byte_lines_oe_n_o)
      else $error("bus not driven during read");
   a_idle_zero: assert property (
      host_byte_lines_oe_n_o |-> host_byte_lines_o == 8'h00)
      else $error("read data not cleared while released");
   a_test_force: assert property (
      !$past(rst_i) && $past(t_en) |-> out_pins_o == $past(lvl))
      else $error("test levels not forced on pins");
   a_serial_mode: assert property (
      !$past(rst_i) && !$past(t_en) && $past(s_en) |->
      out_pins_o == (($past(lvl) & ~SERIAL_MASK) |
      ($past(func_pins_i) & SERIAL_MASK)))
      else $error("serial mode pin levels wrong");
   a_func_pass: assert property (
      !$past(rst_i) && !$past(t_en) && !$past(s_en) |->
      out_pins_o == $past(func_pins_i))
      else $error("pins do not follow core levels");
endmodule // thcp_chk

bind thcp_top thcp_chk #(.OUT_W(OUT_W), .SERIAL_MASK(SERIAL_MASK)) u_chk
(
   .clock_i(clock_i), .rst_i(rst_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
   .direct_freq_commit_i(direct_freq_commit_i),
   .carrier_offset_serial_i(carrier_offset_serial_i),
   .func_pins_i(func_pins_i), .host_byte_lines_o(host_byte_lines_o),
   .host_byte_lines_oe_n_o(host_byte_lines_oe_n_o),
   .out_pins_o(out_pins_o), .control_words_o(control_words_o),
   .carrier_center_frequency_o(carrier_center_frequency_o),
   .resampler_center_frequency_o(resampler_center_frequency_o),
   .phase_oscillator_freq_o(phase_oscillator_freq_o)
);

// *** testbench/thcp_host_model.sv ***
// host microprocessor model for the tuner port
`timescale 1ns/1ps
module thcp_host_model
(
   input  wire        clock_i,
   output logic [2:0] sel_o,
   output logic [7:0] data_o,
   output logic       wr_n_o,
   output logic       rd_n_o,
   output logic       load_o
);
   initial
   begin
      sel_o = 3'h0;
      data_o = 8'h00;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      load_o = 1'b0;
   end
   // write and read strobes skewed 1 ns past the falling edge, clear of the rising sampling edge
   task automatic write(input logic [2:0] s, input logic [7:0] d);
      @(negedge clock_i);
      #1 sel_o = s;
      data_o = d;
      wr_n_o = 1'b0;
      repeat (4) @(negedge clock_i);
      #1 wr_n_o = 1'b1;
      repeat (4) @(negedge clock_i);
      data_o = ~d;
   endtask
   task automatic read();
      @(negedge clock_i);
      #1 rd_n_o = 1'b0;
      repeat (10) @(negedge clock_i);
      #1 rd_n_o = 1'b1;
      repeat (5) @(negedge clock_i);
   endtask
   task automatic load();
      @(negedge clock_i);
      load_o = 1'b1;
      @(negedge clock_i);
      load_o = 1'b0;
   endtask
endmodule // thcp_host_model

// *** verilog/thcp_pin_force.v ***
// one output pin with test-mode and serial-mode level forcing
`timescale 1ns/1ps

module thcp_pin_force
#(
   parameter SERIAL_USED = 1'b0
)
(
   input  wire clock_i,
   input  wire rst_i,
   input  wire func_i,
   input  wire test_en_i,
   input  wire serial_mode_i,
   input  wire level_i,
   output wire pin_o
);

   reg pin_reg;
   reg pin_next;

   always @*
   begin
      pin_next = func_i;
      if (test_en_i)
         pin_next = level_i;
      else if (serial_mode_i && !SERIAL_USED)
         pin_next = level_i;
   end

   always @(posedge clock_i)
   begin
      if (rst_i)
         pin_reg <= 1'b0;
      else
         pin_reg <= pin_next;
   end

   assign pin_o = pin_reg;

endmodule // thcp_pin_force

// *** verilog/thcp_sync.v ***
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps

module thcp_sync
#(
   parameter RESET_VAL = 1'b1
)
(
   input  wire clock_i,
   input  wire rst_i,
   input  wire async_i,
   output wire sync_o
);

   reg meta_reg;
   reg sync_reg;

   // first stage feeds only the second stage
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule // thcp_sync

// *** verilog/thcp_top.v ***
// tuner host control port: staging, commit, snapshot read and test forcing
`timescale 1ns/1ps
`include "thcp_regs.vh"

module thcp_top
#(
   parameter                 OUT_W       = 16,
   parameter [OUT_W-1:0]     SERIAL_MASK = 16'h00FF
)
(
   input  wire                            clock_i,
   input  wire                            rst_i,
   input  wire [2:0]                      host_select_lines_i,
   input  wire [`THCP_BYTE_W-1:0]         host_byte_lines_i,
   output wire [`THCP_BYTE_W-1:0]         host_byte_lines_o,
   output wire                            host_byte_lines_oe_n_o,
   input  wire                            wr_n_i,
   input  wire                            rd_n_i,
   input  wire                            direct_freq_commit_i,
   input  wire [`THCP_WORD_W-1:0]         carrier_offset_serial_i,
   input  wire [2:0]                      gain_control_loop_exp_i,
   input  wire [4:0]                      gain_control_loop_frac_i,
   input  wire [OUT_W-1:0]                func_pins_i,
   output wire [OUT_W-1:0]                out_pins_o,
   output wire [`THCP_WORD_W-1:0]         carrier_center_frequency_o,
   output wire [`THCP_WORD_W-1:0]         resampler_center_frequency_o,
   output wire [`THCP_WORD_W-1:0]         phase_oscillator_freq_o,
   output wire [`THCP_NUM_CTRL*`THCP_WORD_W-1:0] control_words_o
);

   // =========================================================
   // strobe synchronisers
   // =========================================================
   wire wr_n_sync;
   wire rd_n_sync;

   thcp_sync
   #(
      .RESET_VAL (1'b1)
   )
   u_wr_sync
   (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i (wr_n_i),
      .sync_o  (wr_n_sync)
   );

   thcp_sync
   #(
      .RESET_VAL (1'b1)
   )
   u_rd_sync
   (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i (rd_n_i),
      .sync_o  (rd_n_sync)
   );

   // =========================================================
   // write capture
   // =========================================================
   // pins are sampled while the raw strobe is low, so the value
   // taken is the last one before the pin rises; the host need not
   // hold address and data past its own rising edge
   reg                      wr_n_prev_reg;
   reg [2:0]                hold_sel_reg;
   reg [`THCP_BYTE_W-1:0]   hold_data_reg;
   wire                     wr_rise;

   assign wr_rise = wr_n_sync & ~wr_n_prev_reg;

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         wr_n_prev_reg <= 1'b1;
         hold_sel_reg  <= `THCP_SEL_STAGE0;
         hold_data_reg <= `THCP_BYTE_RESET;
      end
      else
      begin
         wr_n_prev_reg <= wr_n_sync;
         if (!wr_n_i)
         begin
            hold_sel_reg  <= host_select_lines_i;
            hold_data_reg <= host_byte_lines_i;
         end
      end
   end

   // =========================================================
   // staging bytes and destination selector
   // =========================================================
   reg [`THCP_BYTE_W-1:0]   stage0_reg;
   reg [`THCP_BYTE_W-1:0]   stage1_reg;
   reg [`THCP_BYTE_W-1:0]   stage2_reg;
   reg [`THCP_BYTE_W-1:0]   stage3_reg;
   reg [`THCP_DEST_W-1:0]   dest_reg;
   wire                     dest_write;
   wire [`THCP_WORD_W-1:0]  staged_word;

   assign dest_write = wr_rise && (hold_sel_reg == `THCP_SEL_DEST);

   // byte 0 is the least significant
   assign staged_word = {stage3_reg, stage2_reg,
                         stage1_reg, stage0_reg};

   // writes are taken every cycle, including the one right after
   // a direct commit; codes above the selector are ignored
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         stage0_reg <= `THCP_BYTE_RESET;
         stage1_reg <= `THCP_BYTE_RESET;
         stage2_reg <= `THCP_BYTE_RESET;
         stage3_reg <= `THCP_BYTE_RESET;
         dest_reg   <= `THCP_DEST_CARRIER;
      end
      else if (wr_rise)
      begin
         case (hold_sel_reg)
            `THCP_SEL_STAGE0: stage0_reg <= hold_data_reg;
            `THCP_SEL_STAGE1: stage1_reg <= hold_data_reg;
            `THCP_SEL_STAGE2: stage2_reg <= hold_data_reg;
            `THCP_SEL_STAGE3: stage3_reg <= hold_data_reg;
            `THCP_SEL_DEST:
               dest_reg <= hold_data_reg[`THCP_DEST_W-1:0];
            default:
               dest_reg <= dest_reg;
         endcase
      end
   end

   // =========================================================
   // commit delay
   // =========================================================
   // counting starts at the synchronised edge, so the commit lands
   // four device clocks after the write is seen in this domain
   // a selector write during the count restarts it; one in the commit cycle still lets that commit land
   localparam ST_IDLE = 1'b0;
   localparam ST_WAIT = 1'b1;

   reg                      pend_reg;
   reg                      pend_next;
   reg [`THCP_CNT_W-1:0]    cnt_reg;
   reg [`THCP_CNT_W-1:0]    cnt_next;
   wire                     commit;

   assign commit = (pend_reg == ST_WAIT) &&
                   (cnt_reg == `THCP_COMMIT_CLKS);

   always @*
   begin
      pend_next = pend_reg;
      cnt_next  = cnt_reg;
      case (pend_reg)
         ST_IDLE:
         begin
            if (dest_write)
            begin
               pend_next = ST_WAIT;
               cnt_next  = `THCP_CNT_START;
            end
         end
         ST_WAIT:
         begin
            if (dest_write)
            begin
               cnt_next  = `THCP_CNT_START;
            end
            else if (commit)
            begin
               pend_next = ST_IDLE;
               cnt_next  = `THCP_CNT_ZERO;
            end
            else
               cnt_next  = cnt_reg + `THCP_CNT_ONE;
         end
         default:
         begin
            pend_next = ST_IDLE;
            cnt_next  = `THCP_CNT_ZERO;
         end
      endcase
   end

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         pend_reg <= ST_IDLE;
         cnt_reg  <= `THCP_CNT_ZERO;
      end
      else
      begin
         pend_reg <= pend_next;
         cnt_reg  <= cnt_next;
      end
   end

   // =========================================================
   // control words
   // =========================================================
   reg [`THCP_WORD_W-1:0]   ctrl_mem [0:`THCP_NUM_CTRL-1];
   integer                  k;

   // the direct pin copies whatever is staged on every high
   // sample, so a stray level keeps overwriting the carrier word
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         for (k = 0; k < `THCP_NUM_CTRL; k = k + 1)
            ctrl_mem[k] <= `THCP_WORD_RESET;
      end
      else
      begin
         if (commit && (dest_reg < `THCP_NUM_CTRL))
            ctrl_mem[dest_reg] <= staged_word;
         if (direct_freq_commit_i)
            ctrl_mem[`THCP_DEST_CARRIER] <= staged_word;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `THCP_NUM_CTRL; g = g + 1)
      begin : g_flat
         assign control_words_o[g*`THCP_WORD_W +: `THCP_WORD_W] =
            ctrl_mem[g];
      end
   endgenerate

   assign carrier_center_frequency_o   = ctrl_mem[`THCP_DEST_CARRIER];
   assign resampler_center_frequency_o =
      ctrl_mem[`THCP_DEST_RESAMPLER];

   // =========================================================
   // mixer oscillator frequency
   // =========================================================
   reg [`THCP_WORD_W-1:0]   mix_freq_reg;

   // two's complement sum wraps modulo the word width
   always @(posedge clock_i)
   begin
      if (rst_i)
         mix_freq_reg <= `THCP_WORD_RESET;
      else
         mix_freq_reg <= ctrl_mem[`THCP_DEST_CARRIER] +
                         carrier_offset_serial_i;
   end

   assign phase_oscillator_freq_o = mix_freq_reg;

   // =========================================================
   // accumulator snapshot and read back
   // =========================================================
   reg [`THCP_BYTE_W-1:0]   snap_reg;
   reg [`THCP_BYTE_W-1:0]   rd_data_reg;
   reg                      rd_oe_n_reg;

   always @(posedge clock_i)
   begin
      if (rst_i)
         snap_reg <= `THCP_BYTE_RESET;
      else if (commit && (dest_reg == `THCP_DEST_SNAPSHOT))
         snap_reg <= {gain_control_loop_exp_i,
                      gain_control_loop_frac_i};
   end

   // the bus lags the strobe by the synchroniser delay plus one register; the host
   // must not drive the lines until three clocks after raising it
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         rd_data_reg <= `THCP_BYTE_RESET;
         rd_oe_n_reg <= 1'b1;
      end
      else
      begin
         rd_oe_n_reg <= rd_n_sync;
         if (!rd_n_sync)
            rd_data_reg <= snap_reg;
         else
            rd_data_reg <= `THCP_BYTE_RESET;
      end
   end

   assign host_byte_lines_o      = rd_data_reg;
   assign host_byte_lines_oe_n_o = rd_oe_n_reg;

   // =========================================================
   // test mode output forcing
   // =========================================================
   wire [`THCP_WORD_W-1:0]  test_word;

   assign test_word = ctrl_mem[`THCP_DEST_TEST];

   generate
      for (g = 0; g < OUT_W; g = g + 1)
      begin : g_pin
         thcp_pin_force
         #(
            .SERIAL_USED (SERIAL_MASK[g])
         )
         u_pin
         (
            .clock_i       (clock_i),
            .rst_i         (rst_i),
            .func_i        (func_pins_i[g]),
            .test_en_i     (test_word[`THCP_TEST_EN_BIT]),
            .serial_mode_i (test_word[`THCP_TEST_SERIAL_BIT]),
            .level_i       (test_word[g]),
            .pin_o         (out_pins_o[g])
         );
      end
   endgenerate

endmodule // thcp_top
